// File: logic/pps_regs.sv
// Purpose: APB register bank selecting the power source of ports 4 and 5
// Assumes: Sources come from other clock domains or pins and are synchronised
// Notes: Zero-wait APB slave, unmapped addresses read zero and raise pslverr
//
// Notes on behaviour
// [R1] Bit 7 chooses shared or separate pins
// [R2] Bit 5 marks port permanently disabled
// [R3] Bit 4 marks non-removable attached device
// [R4] Code 0000b keeps port power off
// [R5] Codes 1,2,3 follow USB2, USB3, either
// [R6] Code 0100b follows designated GPIO line
// [R7] Software writes only the five defined codes
// [R8] Settings loaded once, not changed dynamically
// [R9] Flag bits set before hub enumerates
// [R10] Bit 6 reserved and read-only
// [R11] Reserved codes keep port power off
`timescale 1ns/1ps
`include "pps_defs.svh"

module pps_regs
    import pps_pkg::*;
#(
    parameter int NPORT = 2
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power sources, index 0 is port 4
    input wire logic usb2_power_on,
    input wire logic usb3_power_on,
    input wire logic [NPORT-1:0] gpio_power_on,
    // Per-port results
    output pps_port_s [NPORT-1:0] port_out
);

////////////////////////////////////////////////////////////////////////////////
// Declarations
////////////////////////////////////////////////////////////////////////////////

    localparam int NSRC = NPORT + 2;

    logic [NSRC-1:0] src_in;
    logic [NSRC-1:0] src_seen;
    logic usb2_seen;
    logic usb3_seen;
    logic [NPORT-1:0] gpio_seen;
    pps_cfg_s [NPORT-1:0] cfg_all;
    logic [NPORT-1:0] hit;
    logic [NPORT-1:0] wr_en;
    logic setup;
    logic access;
    logic upper_zero;
    logic mapped;
    logic [31:0] rdata_nxt;

////////////////////////////////////////////////////////////////////////////////
// Source synchronisers
////////////////////////////////////////////////////////////////////////////////

    // Bit 0 is USB2 power, bit 1 USB3 power, the rest one GPIO line per port
    assign src_in = {gpio_power_on, usb3_power_on, usb2_power_on};

    genvar s;
    generate
        for (s = 0; s < NSRC; s++) begin : g_sync
            logic meta_r;
            logic sync_r;

            // Only the second stage is read; the first may be metastable
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= src_in[s];
                    sync_r <= meta_r;
                end
            end

            assign src_seen[s] = sync_r;
        end
    endgenerate

    assign usb2_seen = src_seen[0];
    assign usb3_seen = src_seen[1];
    assign gpio_seen = src_seen[NSRC-1:2];

////////////////////////////////////////////////////////////////////////////////
// Bus decode
////////////////////////////////////////////////////////////////////////////////

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign upper_zero = (paddr[31:`PPS_ADDR_W] == '0);
    assign mapped = |hit;

////////////////////////////////////////////////////////////////////////////////
// Port registers
////////////////////////////////////////////////////////////////////////////////

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            localparam logic [`PPS_ADDR_W-1:0] OFS =
                `PPS_ADDR_W'(`PPS_PORT4_OFFSET + 4 * g);
            pps_cfg_s cfg_r;
            logic power_nxt;
            logic power_r;
            logic shared_r;
            logic disabled_r;
            logic fixed_r;

            assign hit[g] = upper_zero && (paddr[`PPS_ADDR_W-1:0] == OFS);
            // Byte lane 0 carries the register; other lanes are ignored
            assign wr_en[g] = access && pwrite && hit[g] && pstrb[0];
            assign cfg_all[g] = cfg_r;

            // Reserved bit is masked so it always reads zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r <= `PPS_CFG_RESET;
                end else if (wr_en[g]) begin
                    cfg_r <= pwdata[7:0] & `PPS_WR_MASK; // [R10]
                end
            end

            // Reserved codes fall to the default and leave the port unpowered
            always_comb begin
                case (pps_code_e'(cfg_r.power_source_code))
                    PPS_SRC_OFF: power_nxt = 1'b0; // [R4]
                    PPS_SRC_USB2: power_nxt = usb2_seen; // [R5]
                    PPS_SRC_USB3: power_nxt = usb3_seen; // [R5]
                    PPS_SRC_EITHER: power_nxt = usb2_seen | usb3_seen; // [R5]
                    PPS_SRC_GPIO: power_nxt = gpio_seen[g]; // [R6]
                    default: power_nxt = 1'b0; // [R11]
                endcase
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    power_r <= 1'b0;
                end else begin
                    power_r <= power_nxt;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    shared_r <= 1'b0;
                end else begin
                    shared_r <= cfg_r.shared_pin; // [R1]
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    disabled_r <= 1'b0;
                end else begin
                    disabled_r <= cfg_r.port_disabled; // [R2]
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fixed_r <= 1'b0;
                end else begin
                    fixed_r <= cfg_r.fixed_attached_device; // [R3]
                end
            end

            assign port_out[g] = {power_r, shared_r, disabled_r, fixed_r};
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// Read-back and response
////////////////////////////////////////////////////////////////////////////////

    // Picked up in the setup cycle so it stands through the access cycle
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        for (int i = 0; i < NPORT; i++) begin
            if (hit[i]) begin
                rdata_nxt = {24'h00_0000, cfg_all[i]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !mapped;
        end
    end

endmodule : pps_regs

// File: logic/pps_defs.svh
// Purpose: Constants for the port power source select register bank
// Assumes: APB byte addresses, 32-bit data, registers in the low byte
// Notes: Offsets are byte addresses of aligned words
`ifndef PPS_DEFS_SVH
`define PPS_DEFS_SVH

`define PPS_ADDR_W 16
`define PPS_PORT4_OFFSET 16'h3C0C
`define PPS_PORT5_OFFSET 16'h3C10
`define PPS_CFG_RESET 8'h00
`define PPS_BIT_SHARED_PIN 7
`define PPS_BIT_RESERVED 6
`define PPS_BIT_DISABLED 5
`define PPS_BIT_FIXED_DEV 4
`define PPS_CODE_MSB 3
`define PPS_CODE_LSB 0
`define PPS_WR_MASK 8'hBF

`endif

// File: logic/pps_pkg.sv
// Purpose: Types for the port power source select register bank
// Assumes: Constants live in pps_defs.svh
// Notes: Codes outside the enum are reserved
package pps_pkg;

    typedef enum logic [3:0] {
        PPS_SRC_OFF = 4'h0,
        PPS_SRC_USB2 = 4'h1,
        PPS_SRC_USB3 = 4'h2,
        PPS_SRC_EITHER = 4'h3,
        PPS_SRC_GPIO = 4'h4
    } pps_code_e;

    // One port register image
    typedef struct packed {
        logic shared_pin;
        logic reserved;
        logic port_disabled;
        logic fixed_attached_device;
        logic [3:0] power_source_code;
    } pps_cfg_s;

    // Per-port decoded outputs
    typedef struct packed {
        logic power_on;
        logic shared_pin;
        logic port_disabled;
        logic fixed_attached_device;
    } pps_port_s;

endpackage : pps_pkg

// File: verif/pps_regs_chk.sv
// Purpose: Port-level checks for pps_regs
// Assumes: Zero-wait APB slave, sources reach power_on in 3 edges
// Notes: Bound to every pps_regs instance
`timescale 1ns/1ps
module pps_regs_chk
    import pps_pkg::*;
#(parameter int NPORT = 2) (
    // Clock, reset and APB
    input logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input logic [31:0] prdata,
    // Sources and results
    input logic usb2_power_on, usb3_power_on,
    input logic [NPORT-1:0] gpio_power_on,
    input pps_port_s [NPORT-1:0] port_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup; psel && !penable; endsequence
    sequence s_rd; pready && !pwrite; endsequence
    sequence s_quiet(i); !usb2_power_on && !usb3_power_on && !gpio_power_on[i]; endsequence
    property p_ack; s_setup |=> pready; endproperty
    a_ack: assert property (p_ack) else $error("no answer after setup");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    property p_b6; s_rd |-> !prdata[6]; endproperty
    a_b6: assert property (p_b6) else $error("reserved bit read as one");
    property p_hi; s_rd |-> prdata[31:8] == 24'h0; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits not zero");
    property p_off0; s_quiet(0) [*3] |=> !port_out[0].power_on; endproperty
    a_off0: assert property (p_off0) else $error("port 4 powered, no source");
    property p_off1; s_quiet(1) [*3] |=> !port_out[1].power_on; endproperty
    a_off1: assert property (p_off1) else $error("port 5 powered, no source");
    property p_keep; !(psel && penable && pwrite) |-> ##2 $stable({port_out[0][2:0],
        port_out[1][2:0]}); endproperty
    a_keep: assert property (p_keep) else $error("flags moved without write");
endmodule : pps_regs_chk
bind pps_regs pps_regs_chk #(.NPORT(NPORT)) pps_regs_chk_inst (.*);

// File: verif/tb_top.sv
// Purpose: Self-checking bench for pps_regs
// Assumes: Zero-wait APB, 3-edge source sync
// Notes: Codes 0..15 swept on port 5
`timescale 1ns/1ps
module tb_top;
    import pps_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic usb2_power_on = 0, usb3_power_on = 0, e;
    logic [1:0] gpio_power_on = 2'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    pps_port_s [1:0] port_out;
    int bad_count = 0, n_checks = 0;
    always #4 pclk = ~pclk;
    pps_regs #(.NPORT(2)) pps_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .usb2_power_on(usb2_power_on),
        .usb3_power_on(usb3_power_on), .gpio_power_on(gpio_power_on), .port_out(port_out));
    task check(input string n, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task t_fields;
        gpio_power_on <= 2'h1;
        apb(1'b1, 32'h3C0C, 32'hF4);
        apb(1'b0, 32'h3C0C, 32'h0);
        check("port4 read", rd, 32'hB4);
        check("port4 flags", port_out[0][2:0], 32'h7);
        check("port5 flags", port_out[1][2:0], 32'h0);
        check("port4 power", port_out[0].power_on, 32'h1);
        pstrb <= 4'hE;
        apb(1'b1, 32'h3C10, 32'hB3);
        pstrb <= 4'hF;
        apb(1'b0, 32'h3C10, 32'h0);
        check("lane0 off write", rd, 32'h0);
        apb(1'b0, 32'h3C14, 32'h0);
        check("unmapped", {er, rd[30:0]}, 32'h80000000);
    endtask : t_fields
    task t_codes;
        for (int c = 0; c < 16; c++) begin
            for (int s = 0; s < 2; s++) begin
                usb2_power_on <= (s == 0); usb3_power_on <= (s == 1);
                gpio_power_on <= (s == 0) ? 2'h2 : 2'h0;
                apb(1'b1, 32'h3C10, c);
                repeat (4) @(posedge pclk);
                case (c)
                    1: e = (s == 0);
                    2: e = (s == 1);
                    3: e = 1'b1;
                    4: e = (s == 0);
                    default: e = 1'b0;
                endcase
                check("port5 power", port_out[1].power_on, e);
                check("port4 power", port_out[0].power_on, 32'h0);
            end
        end
    endtask : t_codes
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_fields;
        t_codes;
        finish_test;
    end
    initial begin
        #50000;
        bad_count++;
        finish_test;
    end
endmodule : tb_top
